// *** bench/tb_top.sv ***
// self-checking bench for the register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   logic cmd_valid, rd_valid, chan, fw, wake, ok;
   logic [1:0] cmd_mode;
   logic [5:0] cmd_addr;
   logic [7:0] cmd_wdata, rdata, v, d;
   logic [4:0] rssi = 5'h00;
   logic [4:0] ev = 5'h00;
   logic [2:0] stc;
   logic gup, pdn, fsel, sar, adm, con, osc, tcut, shy, hro, gdn, trim;
   logic [1:0] mres, ptol, ftol, dres;
   logic [2:0] ecst, rxto;
   logic [3:0] gcut;
   logic [4:0] hbl;
   logic [15:0] wpat;
   logic [7:0] m [0:14];
   logic [31:0] seed = 32'h4202;
   int err_total = 0;
   int n_compared = 0;
   int n;
   always #10 clk_sys = ~clk_sys;
   wkr_host_model host_u (.clk_sys(clk_sys), .cmd_valid(cmd_valid), .cmd_mode(cmd_mode),
      .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .rdata(rdata), .rd_valid(rd_valid));
   wkr_cfg_regs #(.MS_CYCLES(20), .FORCED_PULSE_CYCLES(16'h0005)) dut_u (.CLK_SYS(clk_sys),
      .RESETN(resetn), .CMD_VALID(cmd_valid), .CMD_MODE(cmd_mode), .CMD_ADDR(cmd_addr),
      .CMD_WDATA(cmd_wdata), .RDATA(rdata), .RD_VALID(rd_valid), .RSSI_IN(rssi),
      .FALSE_WAKE_IN(ev[0]), .FIELD_DETECT_IN(ev[2]), .PATTERN_HIT_IN(ev[1]),
      .PATTERN_MISS_IN(ev[3]), .BURST_END_IN(ev[4]), .CHANNEL_ON(chan), .POWER_DOWN(pdn),
      .FORBIDDEN_SELECT(fsel), .MAIN_RESERVED(mres), .GAIN_UP_EN(gup), .GAIN_DOWN_EN(gdn),
      .ANTENNA_DAMPER_ON(adm), .CORRELATOR_ON(con), .OSC_ENABLE(osc),
      .SLICER_ABSOLUTE_REF(sar), .SLICER_THRESHOLD_CUT(tcut), .PATTERN_TOLERANCE(ptol),
      .FREQUENCY_TOLERANCE(ftol), .SLICER_SMALL_HYSTERESIS(shy),
      .HYSTERESIS_RISING_ONLY(hro), .SLICER_TIME_CONST(stc), .ENVELOPE_TIME_CONST(ecst),
      .DAMPING_RESISTOR(dres), .GAIN_CUT(gcut), .WAKE_PATTERN(wpat), .RX_TIMEOUT(rxto),
      .HALF_BIT_LENGTH(hbl), .WAKE(wake), .FORCED_WAKE(fw), .TRIM_OSC_START(trim));
   function automatic logic [31:0] nx();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic pick(input int w);
      return (w == 0) ? chan : fw;
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic span(input int w, input logic lv, output int k);
      k = 0;
      while (pick(w) !== lv && k < 21000) begin
         @(posedge clk_sys);
         #1;
         k++;
      end
   endtask
   task automatic defaults();
      for (int i = 0; i < 15; i++) m[i] = (i < 9) ? wkr_pkg::CFG_RESET[i] : 8'h00;
      m[10] = {3'h0, rssi};
   endtask
   task automatic readall();
      for (int a = 0; a < 15; a++) begin
         host_u.rd(6'(a), v, ok);
         chk(ok, 1'b1);
         chk(v, m[a]);
      end
      outs();
   endtask
   task automatic outs();
      chk({pdn, fsel, mres}, {m[0][0], m[0][4], m[0][3:2]});
      chk({sar, adm, con, osc}, {m[1][7], m[1][4], m[1][1:0]});
      chk({tcut, ptol, ftol}, {m[2][7:5], m[2][1:0]});
      chk({shy, hro, stc, ecst}, m[3]);
      chk({dres, gcut, wpat}, {m[4][5:0], m[6], m[5]});
      chk({rxto, hbl}, m[7]);
   endtask
   task automatic pulse(input int b);
      ev[b] = 1'b1;
      repeat (8) @(posedge clk_sys);
      #1;
      ev[b] = 1'b0;
      repeat (8) @(posedge clk_sys);
      #1;
   endtask
   task automatic summarize();
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      #1_000_000;
      err_total++;
      summarize();
   end
   initial begin
      rssi = 5'(nx());
      defaults();
      repeat (5) @(posedge clk_sys);
      #1;
      resetn = 1'b1;
      readall();
      $display("test reset values done");
      for (int k = 0; k < 30; k++) begin
         d = 8'(nx());
         host_u.wr(6'(k % 15), d);
         if (k % 15 < 9) begin
            if (k % 15 == 0) d &= 8'hef;
            m[k%15] = (m[k%15] & ~wkr_pkg::CFG_WMASK[k%15]) | (d & wkr_pkg::CFG_WMASK[k%15]);
         end
      end
      readall();
      chk(stc, m[3][5:3]);
      chk(gup, m[1][5]);
      $display("test random writes done");
      host_u.dc(wkr_pkg::CMD_RESTORE);
      defaults();
      m[0] = 8'h02;
      readall();
      $display("test restore done");
      host_u.wr(6'h00, 8'h22);
      for (int s = 0; s < 4; s++) begin
         host_u.wr(6'h04, {2'(s), 6'h10});
         span(0, 1'b1, n);
         span(0, 1'b0, n);
         span(0, 1'b1, n);
         chk(n, 20 << s);
         span(0, 1'b0, n);
         chk(n, 20);
      end
      host_u.wr(6'h00, 8'h02);
      $display("test duty cycle done");
      host_u.wr(6'h08, 8'h01);
      span(1, 1'b1, n);
      span(1, 1'b0, n);
      chk(n, 5);
      host_u.wr(6'h08, 8'h00);
      $display("test forced wake done");
      host_u.wr(6'h01, 8'h27);
      pulse(1);
      chk(wake, 1'b0);
      pulse(1);
      chk(wake, 1'b1);
      host_u.dc(wkr_pkg::CMD_CLEAR_WAKE);
      chk(wake, 1'b0);
      pulse(1);
      pulse(3);
      pulse(1);
      chk(wake, 1'b0);
      repeat (3) pulse(0);
      host_u.rd(6'h0d, v, ok);
      chk(v, 8'h03);
      host_u.dc(wkr_pkg::CMD_CLEAR_FALSE);
      host_u.rd(6'h0d, v, ok);
      chk(v, 8'h00);
      host_u.dc(wkr_pkg::CMD_TRIM_OSC);
      chk(trim, 1'b1);
      @(posedge clk_sys);
      #1;
      chk(trim, 1'b0);
      host_u.wr(6'h01, 8'h60);
      chk(gup, 1'b1);
      pulse(4);
      chk({gup, gdn}, 2'h0);
      host_u.dc(wkr_pkg::CMD_CLEAR_WAKE);
      chk(gdn, 1'b1);
      host_u.wr(6'h01, 8'h00);
      chk({gup, gdn}, 2'h1);
      $display("test wake and tally done");
      summarize();
   end
endmodule
`default_nettype wire

// *** bench/wkr_host_model.sv ***
// host model issuing write, read and direct commands
`timescale 1ns/1ps
`default_nettype none
module wkr_host_model (
   input wire logic clk_sys, // system clock
   output logic cmd_valid, // command strobe
   output logic [1:0] cmd_mode, // command mode
   output logic [5:0] cmd_addr, // address or code
   output logic [7:0] cmd_wdata, // write data
   input wire logic [7:0] rdata, // read data
   input wire logic rd_valid // read data strobe
);
   initial begin
      cmd_valid = 1'b0;
      cmd_mode = 2'h2;
      cmd_addr = 6'h3f;
      cmd_wdata = 8'h00;
   end
   task automatic issue(input logic [1:0] md, input logic [5:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      #1;
      cmd_valid = 1'b1;
      cmd_mode = md;
      cmd_addr = a;
      cmd_wdata = d;
      @(posedge clk_sys);
      #1;
      cmd_valid = 1'b0;
      cmd_mode = 2'h2;
      cmd_addr = ~a;
      cmd_wdata = ~d;
   endtask
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      issue(wkr_pkg::MODE_WRITE, a, (a == 6'h00) ? (d & 8'hef) : d);
   endtask
   task automatic rd(input logic [5:0] a, output logic [7:0] v, output logic ok);
      issue(wkr_pkg::MODE_READ, a, 8'h00);
      v = rdata;
      ok = rd_valid;
   endtask
   task automatic dc(input logic [5:0] c);
      issue(wkr_pkg::MODE_DIRECT, c, 8'h00);
      if (c == wkr_pkg::CMD_RESTORE) begin
         wr(6'h00, 8'h02);
      end
   endtask
endmodule
`default_nettype wire

// *** include/wkr_pkg.sv ***
// shared constants and types for the wake-up receiver register bank
package wkr_pkg;
   // system clock and derived timing
   localparam int unsigned CLK_HZ = 50_000_000;
   localparam int unsigned TICK_MS = 1;
   localparam int unsigned MS_CYCLES = CLK_HZ / 1000 * TICK_MS;
   localparam int unsigned FORCED_PULSE_US = 128;
   localparam logic [15:0] FORCED_PULSE_CYCLES = 16'(CLK_HZ / 1_000_000 * FORCED_PULSE_US);
   localparam int unsigned ON_TIME_MS = 1;

   // command port modes
   localparam logic [1:0] MODE_WRITE = 2'h0;
   localparam logic [1:0] MODE_READ = 2'h1;
   localparam logic [1:0] MODE_DIRECT = 2'h3;

   // direct command codes
   localparam logic [5:0] CMD_CLEAR_WAKE = 6'h00;
   localparam logic [5:0] CMD_RESET_RSSI = 6'h01;
   localparam logic [5:0] CMD_TRIM_OSC = 6'h02;
   localparam logic [5:0] CMD_CLEAR_FALSE = 6'h03;
   localparam logic [5:0] CMD_RESTORE = 6'h04;

   // register addresses
   localparam logic [5:0] ADDR_MAIN_CONTROL = 6'h00;
   localparam logic [5:0] ADDR_PERIODIC = 6'h08;
   localparam logic [5:0] ADDR_RESERVED_CONFIG = 6'h09;
   localparam logic [5:0] ADDR_SIGNAL_STRENGTH = 6'h0a;
   localparam logic [5:0] ADDR_UNUSED_A = 6'h0b;
   localparam logic [5:0] ADDR_UNUSED_B = 6'h0c;
   localparam logic [5:0] ADDR_FALSE_COUNT = 6'h0d;

   // reset values and writable masks of the nine stored registers, index 8 first
   localparam logic [8:0][7:0] CFG_RESET = {8'h00, 8'h0b, 8'h96, 8'h69, 8'h10,
                                            8'h20, 8'h00, 8'h23, 8'h0e};
   localparam logic [8:0][7:0] CFG_WMASK = {8'h07, 8'hff, 8'hff, 8'hff, 8'hff,
                                            8'hff, 8'he3, 8'hf7, 8'h3f};

   // field positions
   localparam int POS_DUTY_LISTEN = 5;
   localparam int POS_FORBIDDEN = 4;
   localparam int POS_CHANNEL_EN = 1;
   localparam int POS_POWER_DOWN = 0;
   localparam int POS_ABS_REF = 7;
   localparam int POS_FIRST_BURST = 6;
   localparam int POS_BIDIR = 5;
   localparam int POS_DAMPER = 4;
   localparam int POS_DOUBLE = 2;
   localparam int POS_CORR_ON = 1;
   localparam int POS_OSC_ON = 0;
   localparam int POS_THR_CUT = 7;
   localparam int POS_PAT_TOL = 5;
   localparam int POS_SMALL_HYST = 7;
   localparam int POS_RISING_ONLY = 6;
   localparam int POS_SLICER_TC = 3;
   localparam int POS_OFF_SEL = 6;
   localparam int POS_DAMP_RES = 4;
   localparam int POS_TIMEOUT = 5;

   typedef enum logic [1:0] {
      DUTY_ON = 2'b01,
      DUTY_OFF = 2'b10
   } wkr_duty_t;

   // periodic wake-up period in milliseconds, zero when disabled
   function automatic logic [22:0] wkr_period_ms(input logic [2:0] sel);
      logic [22:0] ms;
      ms = 23'h000000;
      unique case (sel)
         3'h1: ms = 23'd1000;
         3'h2: ms = 23'd5000;
         3'h3: ms = 23'd20000;
         3'h4: ms = 23'd120000;
         3'h5: ms = 23'd900000;
         3'h6: ms = 23'd3600000;
         3'h7: ms = 23'd7200000;
         default: ms = 23'h000000;
      endcase
      return ms;
   endfunction
endpackage

// *** rtl/wkr_cfg_regs.sv ***
// configuration and status register bank of the wake-up receiver
// Notes on behaviour
// - duty listen alternates on, off 1/2/4/8 ms
// - first-burst-only freezes gain control after burst
// - bidirectional gain may rise; otherwise only lowers
// - double pattern needs two successive matches
// - absolute reference bit selects slicer reference
// - threshold cut bit lowers slicer threshold
// - pattern tolerance sets accepted correlator mismatches
// - frequency tolerance sets carrier detection strictness
// - small hysteresis bit picks 20 mV
// - rising-only bit limits hysteresis to positive edges
// - slicer time constant resets to 100
// - envelope time constant resets to 000
// - half bit length resets to 01011
// - periodic wake gives 128 us pulse
// - clear command zeroes false wake tally
`timescale 1ns/1ps
`default_nettype none
module wkr_cfg_regs #(
   parameter int unsigned MS_CYCLES = wkr_pkg::MS_CYCLES,
   parameter logic [15:0] FORCED_PULSE_CYCLES = wkr_pkg::FORCED_PULSE_CYCLES
) (
   input wire logic CLK_SYS,                 // system clock 50 MHz
   input wire logic RESETN,                  // synchronous reset, active low
   input wire logic CMD_VALID,               // command strobe
   input wire logic [1:0] CMD_MODE,          // write, read or direct command
   input wire logic [5:0] CMD_ADDR,          // register address or command code
   input wire logic [7:0] CMD_WDATA,         // write data
   output logic [7:0] RDATA,                 // read data
   output logic RD_VALID,                    // read data valid pulse
   input wire logic [4:0] RSSI_IN,           // front-end signal strength
   input wire logic FALSE_WAKE_IN,           // false wake-up event level
   input wire logic FIELD_DETECT_IN,         // carrier detected level
   input wire logic PATTERN_HIT_IN,          // correlator match level
   input wire logic PATTERN_MISS_IN,         // correlator mismatch level
   input wire logic BURST_END_IN,            // end of carrier burst level
   output logic CHANNEL_ON,                  // channel amplifier active
   output logic POWER_DOWN,                  // power down
   output logic FORBIDDEN_SELECT,            // must stay zero
   output logic [1:0] MAIN_RESERVED,         // main control bits 3:2
   output logic GAIN_UP_EN,                  // gain control may raise
   output logic GAIN_DOWN_EN,                // gain control may lower
   output logic ANTENNA_DAMPER_ON,           // antenna damper
   output logic CORRELATOR_ON,               // pattern correlation enabled
   output logic OSC_ENABLE,                  // crystal oscillator enable
   output logic SLICER_ABSOLUTE_REF,         // slicer absolute reference
   output logic SLICER_THRESHOLD_CUT,        // slicer threshold reduction
   output logic [1:0] PATTERN_TOLERANCE,     // correlator mismatch tolerance
   output logic [1:0] FREQUENCY_TOLERANCE,   // carrier detect tolerance
   output logic SLICER_SMALL_HYSTERESIS,     // 1 gives 20 mV, 0 gives 40 mV
   output logic HYSTERESIS_RISING_ONLY,      // hysteresis on rising edges only
   output logic [2:0] SLICER_TIME_CONST,     // slicer time constant
   output logic [2:0] ENVELOPE_TIME_CONST,   // envelope detector time constant
   output logic [1:0] DAMPING_RESISTOR,      // antenna damping resistor
   output logic [3:0] GAIN_CUT,              // gain reduction
   output logic [15:0] WAKE_PATTERN,         // first byte high, second low
   output logic [2:0] RX_TIMEOUT,            // automatic receive timeout
   output logic [4:0] HALF_BIT_LENGTH,       // bit rate definition
   output logic WAKE,                        // field wake-up level
   output logic FORCED_WAKE,                 // periodic wake-up pulse
   output logic TRIM_OSC_START               // oscillator trim start pulse
);
   typedef struct packed {
      logic [8:0][7:0] cfg;
      logic [7:0] tally;
      logic [4:0] rssi;
      logic [7:0] rdata;
      logic rd_valid;
      logic wake;
      logic first_hit;
      logic burst_seen;
      logic [4:0] evt_prev;
      wkr_pkg::wkr_duty_t duty;
      logic [3:0] off_cnt;
      logic [22:0] auto_cnt;
      logic forced;
      logic [15:0] forced_cnt;
      logic trim;
   } wkr_state_t;

   localparam wkr_state_t ST_RESET = '{cfg: wkr_pkg::CFG_RESET, duty: wkr_pkg::DUTY_ON,
                                       default: '0};

   wkr_state_t st_ff;
   wkr_state_t nxt_st;
   logic [9:0] sync_q;
   logic duty_tick;
   logic auto_tick;
   logic duty_act;
   logic auto_off;
   logic cmd_wr;
   logic cmd_rd;
   logic cmd_dc;
   logic [4:0] rise;
   logic pd;
   logic hold;
   logic declare;
   logic [22:0] period_ms;

   wkr_sync #(.W(10)) u_sync (
      .clk_sys(CLK_SYS),
      .resetn(RESETN),
      .d({BURST_END_IN, PATTERN_MISS_IN, PATTERN_HIT_IN, FIELD_DETECT_IN,
          FALSE_WAKE_IN, RSSI_IN}),
      .q(sync_q)
   );

   wkr_tick #(.N(MS_CYCLES)) u_duty_tick (
      .clk_sys(CLK_SYS),
      .resetn(RESETN),
      .restart(!duty_act),
      .tick(duty_tick)
   );

   wkr_tick #(.N(MS_CYCLES)) u_auto_tick (
      .clk_sys(CLK_SYS),
      .resetn(RESETN),
      .restart(auto_off),
      .tick(auto_tick)
   );

   assign cmd_wr = CMD_VALID && (CMD_MODE == wkr_pkg::MODE_WRITE);
   assign cmd_rd = CMD_VALID && (CMD_MODE == wkr_pkg::MODE_READ);
   assign cmd_dc = CMD_VALID && (CMD_MODE == wkr_pkg::MODE_DIRECT);
   assign pd = st_ff.cfg[0][wkr_pkg::POS_POWER_DOWN];
   assign duty_act = st_ff.cfg[0][wkr_pkg::POS_DUTY_LISTEN] && !pd
                     && st_ff.cfg[0][wkr_pkg::POS_CHANNEL_EN];
   assign period_ms = wkr_pkg::wkr_period_ms(st_ff.cfg[8][2:0]);
   assign auto_off = pd || (period_ms == 23'h000000);
   // bits: burst, miss, hit, field, false
   assign rise = sync_q[9:5] & ~st_ff.evt_prev;
   assign hold = st_ff.cfg[1][wkr_pkg::POS_FIRST_BURST] && st_ff.burst_seen;

   always_comb begin
      logic [7:0] rd_byte;
      logic [3:0] idx;
      rd_byte = 8'h00;
      idx = CMD_ADDR[3:0];
      nxt_st = st_ff;
      declare = 1'b0;

      // register writes; read-only and unmapped addresses are ignored
      if (cmd_wr && (CMD_ADDR <= wkr_pkg::ADDR_PERIODIC)) begin
         nxt_st.cfg[idx] = (CMD_WDATA & wkr_pkg::CFG_WMASK[idx])
                           | (st_ff.cfg[idx] & ~wkr_pkg::CFG_WMASK[idx]);
      end
      if (cmd_dc && (CMD_ADDR == wkr_pkg::CMD_RESTORE)) begin
         nxt_st.cfg = wkr_pkg::CFG_RESET;
      end

      // register reads
      if (CMD_ADDR <= wkr_pkg::ADDR_PERIODIC) begin
         rd_byte = st_ff.cfg[idx];
      end else if (CMD_ADDR == wkr_pkg::ADDR_SIGNAL_STRENGTH) begin
         rd_byte = {3'h0, st_ff.rssi};
      end else if (CMD_ADDR == wkr_pkg::ADDR_FALSE_COUNT) begin
         rd_byte = st_ff.tally;
      end
      nxt_st.rd_valid = cmd_rd;
      if (cmd_rd) begin
         nxt_st.rdata = rd_byte;
      end

      nxt_st.evt_prev = sync_q[9:5];
      nxt_st.trim = cmd_dc && (CMD_ADDR == wkr_pkg::CMD_TRIM_OSC);

      // signal strength peak hold, restarted by command
      if (cmd_dc && (CMD_ADDR == wkr_pkg::CMD_RESET_RSSI)) begin
         nxt_st.rssi = sync_q[4:0];
      end else if (sync_q[4:0] > st_ff.rssi) begin
         nxt_st.rssi = sync_q[4:0];
      end

      // false wake tally, an event in the clear cycle still counts
      if (cmd_dc && (CMD_ADDR == wkr_pkg::CMD_CLEAR_FALSE)) begin
         nxt_st.tally = {7'h00, rise[0]};
      end else if (rise[0] && (st_ff.tally != 8'hff)) begin
         nxt_st.tally = st_ff.tally + 8'h01;
      end

      // wake declaration from field or pattern
      if (!pd) begin
         if (!st_ff.cfg[1][wkr_pkg::POS_CORR_ON]) begin
            declare = rise[1];
         end else if (rise[2]) begin
            if (!st_ff.cfg[1][wkr_pkg::POS_DOUBLE] || st_ff.first_hit) begin
               declare = 1'b1;
               nxt_st.first_hit = 1'b0;
            end else begin
               nxt_st.first_hit = 1'b1;
            end
         end else if (rise[3]) begin
            nxt_st.first_hit = 1'b0;
         end
      end
      if (cmd_dc && (CMD_ADDR == wkr_pkg::CMD_CLEAR_WAKE)) begin
         nxt_st.wake = declare;
         nxt_st.first_hit = 1'b0;
      end else if (declare) begin
         nxt_st.wake = 1'b1;
      end

      // gain control burst tracking
      if (!st_ff.cfg[1][wkr_pkg::POS_FIRST_BURST]
          || (cmd_dc && (CMD_ADDR == wkr_pkg::CMD_CLEAR_WAKE))) begin
         nxt_st.burst_seen = 1'b0;
      end
      if (rise[4]) begin
         nxt_st.burst_seen = 1'b1;
      end

      // listening duty cycle
      if (!duty_act) begin
         nxt_st.duty = wkr_pkg::DUTY_ON;
         nxt_st.off_cnt = 4'h0;
      end else if (duty_tick) begin
         unique case (st_ff.duty)
            wkr_pkg::DUTY_ON: begin
               nxt_st.duty = wkr_pkg::DUTY_OFF;
               nxt_st.off_cnt = 4'h0;
            end
            wkr_pkg::DUTY_OFF: begin
               if (st_ff.off_cnt >= ((4'h1 << st_ff.cfg[4][7:6]) - 4'h1)) begin
                  nxt_st.duty = wkr_pkg::DUTY_ON;
               end else begin
                  nxt_st.off_cnt = st_ff.off_cnt + 4'h1;
               end
            end
            default: begin
               nxt_st.duty = wkr_pkg::DUTY_ON;
            end
         endcase
      end

      // periodic forced wake-up with short pulse
      if (auto_off) begin
         nxt_st.auto_cnt = 23'h000000;
      end else if (auto_tick) begin
         if (st_ff.auto_cnt == (period_ms - 23'h000001)) begin
            nxt_st.auto_cnt = 23'h000000;
            nxt_st.forced = 1'b1;
            nxt_st.forced_cnt = FORCED_PULSE_CYCLES - 16'h0001;
         end else begin
            nxt_st.auto_cnt = st_ff.auto_cnt + 23'h000001;
         end
      end
      if (st_ff.forced && !(auto_tick && !auto_off
                            && st_ff.auto_cnt == (period_ms - 23'h000001))) begin
         if (st_ff.forced_cnt == 16'h0000) begin
            nxt_st.forced = 1'b0;
         end else begin
            nxt_st.forced_cnt = st_ff.forced_cnt - 16'h0001;
         end
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (!RESETN) begin
         st_ff <= ST_RESET;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign RDATA = st_ff.rdata;
   assign RD_VALID = st_ff.rd_valid;
   assign CHANNEL_ON = !pd && st_ff.cfg[0][wkr_pkg::POS_CHANNEL_EN]
                       && (st_ff.duty == wkr_pkg::DUTY_ON);
   assign POWER_DOWN = pd;
   assign FORBIDDEN_SELECT = st_ff.cfg[0][wkr_pkg::POS_FORBIDDEN];
   assign MAIN_RESERVED = st_ff.cfg[0][3:2];
   assign GAIN_UP_EN = st_ff.cfg[1][wkr_pkg::POS_BIDIR] && !hold;
   assign GAIN_DOWN_EN = !hold;
   assign ANTENNA_DAMPER_ON = st_ff.cfg[1][wkr_pkg::POS_DAMPER];
   assign CORRELATOR_ON = st_ff.cfg[1][wkr_pkg::POS_CORR_ON];
   assign OSC_ENABLE = st_ff.cfg[1][wkr_pkg::POS_OSC_ON];
   assign SLICER_ABSOLUTE_REF = st_ff.cfg[1][wkr_pkg::POS_ABS_REF];
   assign SLICER_THRESHOLD_CUT = st_ff.cfg[2][wkr_pkg::POS_THR_CUT];
   assign PATTERN_TOLERANCE = st_ff.cfg[2][wkr_pkg::POS_PAT_TOL +: 2];
   assign FREQUENCY_TOLERANCE = st_ff.cfg[2][1:0];
   assign SLICER_SMALL_HYSTERESIS = st_ff.cfg[3][wkr_pkg::POS_SMALL_HYST];
   assign HYSTERESIS_RISING_ONLY = st_ff.cfg[3][wkr_pkg::POS_RISING_ONLY];
   assign SLICER_TIME_CONST = st_ff.cfg[3][wkr_pkg::POS_SLICER_TC +: 3];
   assign ENVELOPE_TIME_CONST = st_ff.cfg[3][2:0];
   assign DAMPING_RESISTOR = st_ff.cfg[4][wkr_pkg::POS_DAMP_RES +: 2];
   assign GAIN_CUT = st_ff.cfg[4][3:0];
   assign WAKE_PATTERN = {st_ff.cfg[6], st_ff.cfg[5]};
   assign RX_TIMEOUT = st_ff.cfg[7][wkr_pkg::POS_TIMEOUT +: 3];
   assign HALF_BIT_LENGTH = st_ff.cfg[7][4:0];
   assign WAKE = st_ff.wake;
   assign FORCED_WAKE = st_ff.forced;
   assign TRIM_OSC_START = st_ff.trim;

   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!RESETN);

   AST_DUTY_ON_TO_OFF: assert property (
      duty_act && st_ff.duty == wkr_pkg::DUTY_ON && duty_tick |=> !CHANNEL_ON)
      else $error("on phase did not end at the millisecond tick");
   AST_DUTY_OFF_SHORT: assert property (
      duty_act && st_ff.duty == wkr_pkg::DUTY_OFF && duty_tick
      && st_ff.cfg[4][7:6] == 2'h0 |=> CHANNEL_ON)
      else $error("shortest off phase lasted more than one millisecond");
   AST_GAIN_FROZEN: assert property (
      st_ff.cfg[1][wkr_pkg::POS_FIRST_BURST] && rise[4] && !cmd_wr && !cmd_dc
      |=> !GAIN_UP_EN && !GAIN_DOWN_EN)
      else $error("gain control still acting after first burst");
   AST_GAIN_DOWN_ONLY: assert property (
      !st_ff.cfg[1][wkr_pkg::POS_BIDIR] |-> !GAIN_UP_EN)
      else $error("gain raise allowed in down-only mode");
   AST_DOUBLE_FIRST: assert property (
      !pd && CORRELATOR_ON && st_ff.cfg[1][wkr_pkg::POS_DOUBLE] && rise[2]
      && !st_ff.first_hit && !WAKE && !cmd_wr && !cmd_dc |=> !WAKE ##0 st_ff.first_hit)
      else $error("wake declared after a single pattern");
   AST_TALLY_CLEAR: assert property (
      cmd_dc && CMD_ADDR == wkr_pkg::CMD_CLEAR_FALSE && !rise[0] |=> st_ff.tally == 8'h00)
      else $error("false wake tally not cleared");
   AST_RO_WRITE: assert property (
      cmd_wr && CMD_ADDR == wkr_pkg::ADDR_FALSE_COUNT && !rise[0] |=> $stable(st_ff.tally))
      else $error("write changed a read-only register");
   AST_RSVD_READ: assert property (
      cmd_rd && CMD_ADDR == wkr_pkg::ADDR_MAIN_CONTROL |=> RD_VALID && RDATA[7:6] == 2'h0)
      else $error("reserved bits of main control read non-zero");
   AST_RESTORE: assert property (
      cmd_dc && CMD_ADDR == wkr_pkg::CMD_RESTORE |=> SLICER_TIME_CONST == 3'h4
      && ENVELOPE_TIME_CONST == 3'h0 && HALF_BIT_LENGTH == 5'h0b && WAKE_PATTERN == 16'h9669)
      else $error("restore did not reload defaults");
   AST_FORCED_START: assert property (
      $rose(FORCED_WAKE) |-> st_ff.forced_cnt == FORCED_PULSE_CYCLES - 16'h0001)
      else $error("forced wake pulse started with wrong length");
   AST_FORCED_END: assert property (
      FORCED_WAKE && st_ff.forced_cnt == 16'h0000 && !auto_tick |=> !FORCED_WAKE)
      else $error("forced wake pulse too long");

   COV_WRITE_READ: cover property (cmd_wr ##1 cmd_rd ##1 RD_VALID);
   COV_FORCED: cover property ($fell(FORCED_WAKE));
   COV_DOUBLE_WAKE: cover property (st_ff.first_hit ##[1:50] $rose(WAKE));
endmodule
`default_nettype wire

// *** rtl/wkr_sync.sv ***
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module wkr_sync #(
   parameter int unsigned W = 1
) (
   input wire logic clk_sys,       // system clock
   input wire logic resetn,        // synchronous reset, active low
   input wire logic [W-1:0] d,     // asynchronous input
   output logic [W-1:0] q          // filtered synchronous level
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] q;
   } wkr_sync_state_t;

   wkr_sync_state_t st_ff;
   wkr_sync_state_t nxt_st;

   always_comb begin
      nxt_st = st_ff;
      nxt_st.s1 = d;
      nxt_st.s2 = st_ff.s1;
      nxt_st.s3 = st_ff.s2;
      // a bit changes only once stages two and three agree
      for (int i = 0; i < W; i++) begin
         if (st_ff.s2[i] == st_ff.s3[i]) begin
            nxt_st.q[i] = st_ff.s3[i];
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign q = st_ff.q;
endmodule
`default_nettype wire

// *** rtl/wkr_tick.sv ***
// restartable divider giving a one-cycle enable every n cycles
`timescale 1ns/1ps
`default_nettype none
module wkr_tick #(
   parameter int unsigned N = 2
) (
   input wire logic clk_sys,   // system clock
   input wire logic resetn,    // synchronous reset, active low
   input wire logic restart,   // hold count at zero
   output logic tick           // one-cycle enable
);
   localparam int unsigned CW = $clog2(N + 1);
   localparam logic [CW-1:0] LAST = CW'(N - 1);

   typedef struct packed {
      logic [CW-1:0] cnt;
      logic tick;
   } wkr_tick_state_t;

   wkr_tick_state_t st_ff;
   wkr_tick_state_t nxt_st;

   always_comb begin
      nxt_st = st_ff;
      nxt_st.tick = 1'b0;
      if (restart) begin
         nxt_st.cnt = '0;
      end else if (st_ff.cnt == LAST) begin
         nxt_st.cnt = '0;
         nxt_st.tick = 1'b1;
      end else begin
         nxt_st.cnt = st_ff.cnt + CW'(1);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign tick = st_ff.tick;
endmodule
`default_nettype wire
